// [src/dbemr_pkg.sv]
// Package: register map, field positions, reset values and widths.
package dbemr_pkg;

   // ********************************************************************
   // Widths
   // ********************************************************************
   localparam int LNK_ADDR_W = 7;
   localparam int DATA_W     = 8;
   localparam int PC_W       = 24;
   localparam int IS_BYTES   = 5;
   localparam int IS_IDX_W   = 3;

   // ********************************************************************
   // Read-only space offsets
   // ********************************************************************
   localparam logic [6:0] OFS_ID_LOW  = 7'h00;
   localparam logic [6:0] OFS_ID_HIGH = 7'h01;

   // ********************************************************************
   // Write-only space offsets
   // ********************************************************************
   localparam logic [6:0] OFS_BUS_CTL = 7'h17;
   localparam logic [6:0] OFS_IS4     = 7'h21;
   localparam logic [6:0] OFS_IS3     = 7'h22;
   localparam logic [6:0] OFS_IS2     = 7'h23;
   localparam logic [6:0] OFS_IS1     = 7'h24;
   localparam logic [6:0] OFS_IS0     = 7'h25;
   localparam logic [6:0] OFS_MEM_WR  = 7'h30;

   // ********************************************************************
   // Bus handover control fields and reset values
   // ********************************************************************
   localparam int         CTL_GRANT_EN    = 7;
   localparam int         CTL_GRANT_FORCE = 6;
   localparam logic [7:0] CTL_WR_MASK     = 8'hc0;
   localparam logic [7:0] CTL_RST         = 8'h00;
   localparam logic [7:0] BYTE_RST        = 8'h00;

   // ********************************************************************
   // Link framing
   // ********************************************************************
   localparam logic [2:0] LNK_LAST_BIT = 3'h7;
   localparam logic [1:0] SYNC_RST     = 2'h1;

endpackage

// [src/dbemr_xfer_if.sv]
// Interface: write event carried from the link domain to the system domain.
`timescale 1ns/1ps
interface dbemr_xfer_if;
   logic       tgl;
   logic [6:0] addr;
   logic [7:0] data;

   modport src (output tgl, output addr, output data);
   modport dst (input tgl, input addr, input data);
endinterface

// [src/dbemr_sync.sv]
// Module: two-stage level synchroniser with a constant reset value.
`timescale 1ns/1ps
module dbemr_sync #(
   parameter int             W   = 1,
   parameter logic [W-1:0]   RST = '0
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // Data
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } dbemr_sync_st_t;

   dbemr_sync_st_t q;
   dbemr_sync_st_t d;

   always_comb begin
      d.meta   = i_d;
      d.stable = q.meta;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= {RST, RST};
      end else begin
         q <= d;
      end
   end

   assign o_q = q.stable;
endmodule

// [src/dbemr_link.sv]
// Module: serial debug link shifter on the link clock.
`timescale 1ns/1ps
module dbemr_link #(
   // Arbitrary neutral identifier value.
   parameter logic [15:0] PRODUCT_ID = 16'h5a3c
) (
   // Link clock and reset
   input  wire logic   i_lnk_clk,
   input  wire logic   i_rst,
   // Serial pins
   input  wire logic   i_lnk_frame,
   input  wire logic   i_lnk_sdi,
   output logic        o_lnk_sdo,
   output logic        o_lnk_sdo_oe,
   // Write events toward the system domain
   dbemr_xfer_if.src   x
);
   import dbemr_pkg::*;

   typedef struct packed {
      logic       addr_ph;
      logic       rd;
      logic [2:0] cnt;
      logic [6:0] addr;
      logic [6:0] sh;
      logic [7:0] out;
      logic       oe;
      logic       tgl;
      logic [6:0] hold_addr;
      logic [7:0] hold_data;
   } dbemr_link_st_t;

   dbemr_link_st_t q;
   dbemr_link_st_t d;
   logic [7:0]     b;

   // The memory port keeps its address so bytes stream into memory.
   function automatic logic [6:0] adv(input logic [6:0] a);
      adv = (a == OFS_MEM_WR) ? a : a + 7'h01; // [RQ12] [RQ17]
   endfunction

   function automatic logic [7:0] rd_byte(input logic [6:0] a);
      case (a)
         OFS_ID_LOW:  rd_byte = PRODUCT_ID[7:0];  // [RQ13]
         OFS_ID_HIGH: rd_byte = PRODUCT_ID[15:8]; // [RQ13]
         default:     rd_byte = BYTE_RST;
      endcase
   endfunction

   always_comb begin
      d = q;
      b = {q.sh, i_lnk_sdi};
      if (!i_lnk_frame) begin
         d.addr_ph = 1'b1;
         d.cnt     = 3'h0;
         d.rd      = 1'b0;
         d.oe      = 1'b0;
      end else begin
         d.sh  = b[6:0];
         d.cnt = q.cnt + 3'h1;
         d.out = {q.out[6:0], 1'b0};
         if (q.cnt == LNK_LAST_BIT) begin
            if (q.addr_ph) begin
               d.addr_ph = 1'b0;
               d.addr    = b[7:1];
               d.rd      = b[0];
               d.oe      = b[0];
               d.out     = rd_byte(b[7:1]);
            end else if (q.rd) begin
               d.addr = adv(q.addr);
               d.out  = rd_byte(adv(q.addr));
            end else begin
               // Held words stay still for a whole byte, far longer than
               // the system side needs to see the toggle and copy them.
               d.hold_addr = q.addr;
               d.hold_data = b;
               d.tgl       = ~q.tgl;
               d.addr      = adv(q.addr); // [RQ8]
            end
         end
      end
   end

   always_ff @(posedge i_lnk_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '{addr_ph: 1'b1, rd: 1'b0, cnt: 3'h0, addr: 7'h00,
                sh: 7'h00, out: 8'h00, oe: 1'b0, tgl: 1'b0,
                hold_addr: 7'h00, hold_data: 8'h00};
      end else begin
         q <= d;
      end
   end

   assign o_lnk_sdo    = q.out[7];
   assign o_lnk_sdo_oe = q.oe;
   assign x.tgl        = q.tgl;
   assign x.addr       = q.hold_addr;
   assign x.data       = q.hold_data;
endmodule

// [src/dbemr_top.sv]
// Module: debug bus handover, instruction injection and memory write port.
//
// Behaviour
// RQ1: Write-only handover control at 17h, reset zero, low six bits reserved.
// RQ2: Grant enable low: external bus requests ignored, grant never asserted; the code still asserts grant while the force bit is one.
// RQ3: Grant enable high: request granted once the running debug work ends.
// RQ4: Force bit one asserts grant; zero releases buses back to debug logic.
// RQ5: Writing store byte 0 leaves break and runs exactly one instruction.
// RQ6: CPU fetches byte 0 as opcode, then bytes 1..4 only as needed.
// RQ7: Master must not inject six-byte instructions; store holds five bytes.
// RQ8: Store bytes 4..0 at 21h..25h; the final byte 0 starts execution.
// RQ9: Each byte to 30h is written to memory at the current PC.
// RQ10: Long mode uses full PC; short mode uses base byte with PC[15:0].
// RQ11: PC advances by one after every memory port byte.
// RQ12: Memory port access keeps the link register address unchanged.
// RQ13: Fixed 16-bit product identifier readable as low and high bytes.
// RQ14: Store bytes and memory port are write-only, undefined after reset.
// RQ15: Master writes handover control only while CPU is halted in break.
// RQ16: Address mode follows the CPU mode bit: zero short, one long.
// RQ17: Other addresses advance by one after each data byte.
// RQ18: Injected instruction completion returns the CPU to break.
`timescale 1ns/1ps
module dbemr_top #(
   // Arbitrary neutral identifier value.
   parameter logic [15:0] PRODUCT_ID = 16'h5a3c
) (
   // System clock and reset
   input  wire logic                          i_mclk,
   input  wire logic                          i_rst,
   // Serial debug link pins
   input  wire logic                          i_lnk_clk,
   input  wire logic                          i_lnk_frame,
   input  wire logic                          i_lnk_sdi,
   output logic                               o_lnk_sdo,
   output logic                               o_lnk_sdo_oe,
   // External bus handover pins
   input  wire logic                          i_ext_bus_request_n,
   output logic                               o_ext_bus_grant_n,
   // CPU state
   input  wire logic [dbemr_pkg::PC_W-1:0]    i_cpu_pc,
   input  wire logic [dbemr_pkg::DATA_W-1:0]  i_short_mode_base_byte,
   input  wire logic                          i_long_address_mode,
   // Memory write path
   output logic                               o_mem_we,
   output logic      [dbemr_pkg::PC_W-1:0]    o_mem_addr,
   output logic      [dbemr_pkg::DATA_W-1:0]  o_mem_data,
   input  wire logic                          i_mem_ack,
   output logic                               o_pc_inc,
   // Instruction injection and fetch
   output logic                               o_exec_start,
   output logic                               o_exec_run,
   input  wire logic                          i_fetch_req,
   input  wire logic [dbemr_pkg::IS_IDX_W-1:0] i_fetch_idx,
   output logic      [dbemr_pkg::DATA_W-1:0]  o_fetch_data,
   output logic                               o_fetch_valid,
   input  wire logic                          i_exec_done
);
   import dbemr_pkg::*;

   // ********************************************************************
   // State
   // ********************************************************************
   typedef struct packed {
      logic [7:0]                   ctl;
      logic [IS_BYTES-1:0][7:0]     istore;
      logic                         exec;
      logic                         start;
      logic                         mem_pend;
      logic [PC_W-1:0]              mem_addr;
      logic [7:0]                   mem_data;
      logic                         pc_inc;
      logic [7:0]                   fetch_data;
      logic                         fetch_valid;
      logic                         grant_n;
      logic                         tgl_seen;
   } dbemr_top_st_t;

   dbemr_top_st_t q;
   dbemr_top_st_t d;

   dbemr_xfer_if  xfer ();

   logic [1:0]    sync_q;
   logic          tgl_s;
   logic          req_n_s;
   logic          ev;
   logic          busy;

   // ********************************************************************
   // Link side and crossing
   // ********************************************************************
   dbemr_link #(
      .PRODUCT_ID (PRODUCT_ID)
   ) u_link (
      .i_lnk_clk    (i_lnk_clk),
      .i_rst        (i_rst),
      .i_lnk_frame  (i_lnk_frame),
      .i_lnk_sdi    (i_lnk_sdi),
      .o_lnk_sdo    (o_lnk_sdo),
      .o_lnk_sdo_oe (o_lnk_sdo_oe),
      .x            (xfer.src)
   );

   // Toggle of the write event and the request pin share one synchroniser;
   // the held address and data are only read after the toggle settles.
   dbemr_sync #(
      .W   (2),
      .RST (SYNC_RST)
   ) u_sync (
      .i_clk (i_mclk),
      .i_rst (i_rst),
      .i_d   ({xfer.tgl, i_ext_bus_request_n}),
      .o_q   (sync_q)
   );

   assign tgl_s   = sync_q[1];
   assign req_n_s = sync_q[0];

   // ********************************************************************
   // Helpers
   // ********************************************************************
   function automatic logic [PC_W-1:0] mem_target(
      input logic            long_mode,
      input logic [7:0]      base,
      input logic [PC_W-1:0] pc
   );
      mem_target = long_mode ? pc : {base, pc[15:0]}; // [RQ10] [RQ16]
   endfunction

   function automatic logic [IS_IDX_W-1:0] store_idx(input logic [6:0] a);
      store_idx = IS_IDX_W'(OFS_IS0 - a);
   endfunction

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb begin
      d             = q;
      d.start       = 1'b0;
      d.pc_inc      = 1'b0;
      d.fetch_valid = 1'b0;
      d.tgl_seen    = tgl_s;
      ev            = tgl_s != q.tgl_seen;

      // PC moves only once memory has taken the byte.
      if (q.mem_pend && i_mem_ack) begin
         d.mem_pend = 1'b0;
         d.pc_inc   = 1'b1; // [RQ11]
      end

      if (q.exec && i_exec_done) begin
         d.exec = 1'b0; // [RQ18]
      end

      if (ev) begin
         case (xfer.addr)
            OFS_BUS_CTL: begin
               d.ctl = xfer.data & CTL_WR_MASK; // [RQ1]
            end
            OFS_IS4, OFS_IS3, OFS_IS2, OFS_IS1: begin
               d.istore[store_idx(xfer.addr)] = xfer.data; // [RQ14]
            end
            OFS_IS0: begin
               d.istore[0] = xfer.data;
               // A second trigger during a run is dropped: one instruction
               // per break, never a queued second one.
               if (!q.exec) begin
                  d.exec  = 1'b1; // [RQ5] [RQ8]
                  d.start = 1'b1;
               end
            end
            OFS_MEM_WR: begin
               d.mem_pend = 1'b1; // [RQ9]
               d.mem_addr = mem_target(i_long_address_mode,
                                       i_short_mode_base_byte, i_cpu_pc);
               d.mem_data = xfer.data;
            end
            default: begin
            end
         endcase
      end

      // Opcode is byte 0; the CPU asks only for bytes it needs.
      if (i_fetch_req) begin
         d.fetch_valid = 1'b1; // [RQ6]
         if (i_fetch_idx < IS_IDX_W'(IS_BYTES)) begin
            d.fetch_data = q.istore[i_fetch_idx];
         end else begin
            d.fetch_data = BYTE_RST;
         end
      end

      // Grant is held once given until force is clear and request or enable goes away.
      busy = q.mem_pend | q.exec | ev;
      if (q.ctl[CTL_GRANT_FORCE]) begin
         d.grant_n = 1'b0; // [RQ4]
      end else if (q.ctl[CTL_GRANT_EN] && !req_n_s) begin
         d.grant_n = q.grant_n & busy; // [RQ3]
      end else begin
         d.grant_n = 1'b1; // [RQ2]
      end
   end

   // ********************************************************************
   // Registers
   // ********************************************************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         q <= '{ctl: CTL_RST, istore: '0, exec: 1'b0, start: 1'b0,
                mem_pend: 1'b0, mem_addr: '0, mem_data: BYTE_RST,
                pc_inc: 1'b0, fetch_data: BYTE_RST, fetch_valid: 1'b0,
                grant_n: 1'b1, tgl_seen: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign o_ext_bus_grant_n = q.grant_n;
   assign o_mem_we          = q.mem_pend;
   assign o_mem_addr        = q.mem_addr;
   assign o_mem_data        = q.mem_data;
   assign o_pc_inc          = q.pc_inc;
   assign o_exec_start      = q.start;
   assign o_exec_run        = q.exec;
   assign o_fetch_data      = q.fetch_data;
   assign o_fetch_valid     = q.fetch_valid;
endmodule

// [verif/dbemr_top_asserts.sv]
// Checker: port-level timing properties of the debug handover block.
`timescale 1ns/1ps
module dbemr_top_asserts (
   input wire logic        i_mclk,
   input wire logic        i_rst,
   input wire logic        o_ext_bus_grant_n,
   input wire logic        o_mem_we,
   input wire logic [23:0] o_mem_addr,
   input wire logic [7:0]  o_mem_data,
   input wire logic        i_mem_ack,
   input wire logic        o_pc_inc,
   input wire logic [23:0] i_cpu_pc,
   input wire logic [7:0]  i_short_mode_base_byte,
   input wire logic        i_long_address_mode,
   input wire logic        o_exec_start,
   input wire logic        o_exec_run,
   input wire logic        i_exec_done,
   input wire logic        i_fetch_req,
   input wire logic        o_fetch_valid
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   mem_hold_a: assert property (
      o_mem_we && !i_mem_ack |=> o_mem_we && $stable({o_mem_addr, o_mem_data}))
      else $error("memory write dropped before ack");
   mem_addr_a: assert property (
      $rose(o_mem_we) |-> o_mem_addr == ($past(i_long_address_mode)
         ? $past(i_cpu_pc)
         : {$past(i_short_mode_base_byte), 16'($past(i_cpu_pc))}))
      else $error("memory write address wrong");
   pc_step_a: assert property (
      o_mem_we && i_mem_ack |=> o_pc_inc && !o_mem_we ##1 !o_pc_inc)
      else $error("pc step missing after write");
   start_pulse_a: assert property (
      o_exec_start |=> !o_exec_start)
      else $error("start longer than one cycle");
   run_start_a: assert property (
      $rose(o_exec_run) |-> o_exec_start)
      else $error("run rose without start");
   run_end_a: assert property (
      o_exec_run && i_exec_done |=> !o_exec_run)
      else $error("run kept after done");
   run_hold_a: assert property (
      o_exec_run && !i_exec_done |=> o_exec_run)
      else $error("run dropped early");
   fetch_ans_a: assert property (
      i_fetch_req |=> o_fetch_valid)
      else $error("fetch not answered");
   grant_idle_a: assert property (
      $fell(o_ext_bus_grant_n) |-> !$past(o_exec_run) && !$past(o_mem_we))
      else $error("grant given while busy");
endmodule
bind dbemr_top dbemr_top_asserts u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
   .o_ext_bus_grant_n(o_ext_bus_grant_n), .o_mem_we(o_mem_we),
   .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .i_mem_ack(i_mem_ack),
   .o_pc_inc(o_pc_inc), .i_cpu_pc(i_cpu_pc),
   .i_short_mode_base_byte(i_short_mode_base_byte),
   .i_long_address_mode(i_long_address_mode), .o_exec_start(o_exec_start),
   .o_exec_run(o_exec_run), .i_exec_done(i_exec_done),
   .i_fetch_req(i_fetch_req), .o_fetch_valid(o_fetch_valid));

// [verif/dbemr_link_master.sv]
// Partner model: serial debug link master sending frames MSB first.
`timescale 1ns/1ps
module dbemr_link_master (
   // Link pins
   output logic      o_clk,
   output logic      o_frame,
   output logic      o_sdi,
   input  wire logic i_sdo,
   input  wire logic i_sdo_oe
);
   initial {o_clk, o_frame, o_sdi} = 3'b000;
   // One header, then n bytes; one clock pulse with frame low ends each frame.
   task automatic xfer(input logic [6:0] a, input logic rw,
                       input logic [39:0] wd, input int n,
                       output logic [39:0] rd);
      logic [7:0] hdr;
      hdr = {a, rw};
      rd = '0;
      o_frame = 1'b1;
      // Five bytes at most fit, the size of the store.
      for (int i = 0; i < 8 * n + 8; i++) begin
         o_sdi = (i < 8) ? hdr[7 - i] : (rw ? ~o_sdi : wd[8 * n + 7 - i]);
         #15;
         if (i >= 8)
            rd = {rd[38:0], i_sdo && i_sdo_oe};
         o_clk = 1'b1;
         #15 o_clk = 1'b0;
      end
      // A released line toggles so that a stale level never reads as data.
      o_frame = 1'b0;
      o_sdi = ~o_sdi;
      #15 o_clk = 1'b1;
      #15 o_clk = 1'b0;
   endtask
endmodule

// [verif/dbemr_top_tb.sv]
// Testbench: link master, CPU model and queued expected results.
`timescale 1ns/1ps
module dbemr_top_tb;
   import dbemr_pkg::*;
   // Arbitrary identifier value.
   localparam logic [15:0] PID = 16'hc3a5;
   logic        i_mclk, i_rst, i_lnk_clk, i_lnk_frame, i_lnk_sdi;
   logic        o_lnk_sdo, o_lnk_sdo_oe, i_ext_bus_request_n;
   logic        o_ext_bus_grant_n, i_long_address_mode, o_mem_we, i_mem_ack;
   logic        o_pc_inc, o_exec_start, o_exec_run, i_fetch_req;
   logic        o_fetch_valid, i_exec_done;
   logic [2:0]  i_fetch_idx;
   logic [7:0]  i_short_mode_base_byte, o_mem_data, o_fetch_data;
   logic [7:0]  isb [5];
   logic [23:0] i_cpu_pc, o_mem_addr, pc0;
   logic [31:0] mem_q [$], fet_q [$], rb;
   logic [39:0] rd, wdat;
   int          n_fail, tests_run, seed, nf, hold, wcnt, n_start;
   dbemr_top #(.PRODUCT_ID(PID)) u_dut (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_lnk_clk(i_lnk_clk), .i_lnk_frame(i_lnk_frame),
      .i_lnk_sdi(i_lnk_sdi), .o_lnk_sdo(o_lnk_sdo),
      .o_lnk_sdo_oe(o_lnk_sdo_oe), .i_ext_bus_request_n(i_ext_bus_request_n),
      .o_ext_bus_grant_n(o_ext_bus_grant_n), .i_cpu_pc(i_cpu_pc),
      .i_short_mode_base_byte(i_short_mode_base_byte),
      .i_long_address_mode(i_long_address_mode), .o_mem_we(o_mem_we),
      .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .i_mem_ack(i_mem_ack),
      .o_pc_inc(o_pc_inc), .o_exec_start(o_exec_start),
      .o_exec_run(o_exec_run), .i_fetch_req(i_fetch_req),
      .i_fetch_idx(i_fetch_idx), .o_fetch_data(o_fetch_data),
      .o_fetch_valid(o_fetch_valid), .i_exec_done(i_exec_done));
   dbemr_link_master u_m (.o_clk(i_lnk_clk), .o_frame(i_lnk_frame),
      .o_sdi(i_lnk_sdi), .i_sdo(o_lnk_sdo), .i_sdo_oe(o_lnk_sdo_oe));
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic grant_is(input logic e);
      chk("grant", 32'(e), 32'(o_ext_bus_grant_n));
   endtask
   task automatic wr(input logic [6:0] a, input logic [39:0] d, input int n);
      u_m.xfer(a, 1'b0, d, n, rd);
      tick(10);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // CPU side: a slow random ack keeps the write held for several cycles.
   always @(posedge i_mclk) begin
      rb = $random(seed);
      if (o_pc_inc)
         i_cpu_pc <= i_cpu_pc + 24'h1;
      wcnt <= o_mem_we ? wcnt + 1 : 0;
      i_mem_ack <= o_mem_we && !i_mem_ack && (rb[0] || wcnt >= 3);
      if (o_mem_we && i_mem_ack)
         chk("mem", mem_q.pop_front(), {o_mem_addr, o_mem_data});
      if (o_fetch_valid)
         chk("fetch", fet_q.pop_front(), 32'(o_fetch_data));
      if (o_exec_start)
         n_start++;
   end
   initial forever begin
      @(posedge i_mclk);
      if (o_exec_start) begin
         for (int k = 0; k < nf; k++) begin
            // Indices past the store answer with the reset byte.
            fet_q.push_back(k < IS_BYTES ? 32'(isb[k])
                            : 32'(BYTE_RST));
            i_fetch_req <= 1'b1;
            i_fetch_idx <= 3'(k);
            tick(1);
            i_fetch_req <= 1'b0;
            tick(1);
         end
         tick(hold);
         i_exec_done <= 1'b1;
         tick(1);
         i_exec_done <= 1'b0;
      end
   end
   initial begin
      seed = 32'h3faf09ef;
      {i_rst, i_ext_bus_request_n, i_long_address_mode} = 3'b110;
      {i_mem_ack, i_fetch_req, i_exec_done, i_fetch_idx} = 6'h0;
      {i_cpu_pc, i_short_mode_base_byte} = 32'h0;
      tick(8);
      i_rst <= 1'b0;
      tick(4);
      i_ext_bus_request_n <= 1'b0;
      tick(12);
      grant_is(1'b1);
      i_ext_bus_request_n <= 1'b1;
      // Control is only written while the CPU sits in break.
      wr(OFS_BUS_CTL, 40'h3f, 1);
      grant_is(1'b1);
      wr(OFS_BUS_CTL, 40'h40, 1);
      grant_is(1'b0);
      wr(OFS_BUS_CTL, 40'h00, 1);
      grant_is(1'b1);
      wr(OFS_BUS_CTL, 40'h80, 1);
      i_ext_bus_request_n <= 1'b0;
      tick(8);
      grant_is(1'b0);
      i_ext_bus_request_n <= 1'b1;
      isb[0] = 8'($random(seed));
      nf = 1;
      hold = 60;
      wr(OFS_IS0, 40'(isb[0]), 1);
      i_ext_bus_request_n <= 1'b0;
      tick(12);
      grant_is(1'b1);
      chk("run", 1, 32'(o_exec_run));
      // A second trigger while running must not start another instruction.
      u_m.xfer(OFS_IS0, 1'b0, 40'h0, 1, rd);
      tick(40);
      grant_is(1'b0);
      chk("run", 0, 32'(o_exec_run));
      i_ext_bus_request_n <= 1'b1;
      wr(OFS_BUS_CTL, 40'h00, 1);
      hold = 2;
      for (int t = 0; t < 3; t++) begin
         for (int k = 0; k < 5; k++)
            isb[k] = 8'($random(seed));
         nf = 2 * t + 2;
         wr(OFS_IS4, {isb[4], isb[3], isb[2], isb[1], isb[0]}, 5);
         tick(20);
      end
      for (int m = 0; m < 2; m++) begin
         i_long_address_mode <= m[0];
         pc0 = m[0] ? 24'($random(seed)) : 24'h12fffe;
         i_cpu_pc <= pc0;
         i_short_mode_base_byte <= 8'($random(seed));
         wdat = 40'($random(seed));
         tick(1);
         for (int k = 0; k < 3; k++)
            mem_q.push_back({m[0] ? pc0 + 24'(k) : {i_short_mode_base_byte,
               16'(pc0 + 24'(k))}, wdat[8 * (2 - k) +: 8]});
         wr(OFS_MEM_WR, wdat, 3);
         tick(6);
         chk("pc", 32'(pc0 + 24'h3), 32'(i_cpu_pc));
      end
      u_m.xfer(OFS_ID_LOW, 1'b1, 40'h0, 2, rd);
      chk("id", 32'({PID[7:0], PID[15:8]}), 32'(rd[15:0]));
      u_m.xfer(OFS_BUS_CTL, 1'b1, 40'h0, 1, rd);
      chk("wo_read", 0, 32'(rd[7:0]));
      tick(10);
      chk("starts", 4, 32'(n_start));
      chk("left", 0, 32'(mem_q.size() + fet_q.size()));
      stop_test();
   end
   initial begin
      #200us;
      n_fail++;
      stop_test();
   end
endmodule
